// file: logic/flq_map.vh
`ifndef FLQ_MAP_VH
`define FLQ_MAP_VH

// ==========================================================
// Bus widths and zero byte
// ==========================================================
`define FLQ_DATA_W         16
`define FLQ_BYTE_W         8
`define FLQ_SEC_OFS_W      12
`define FLQ_ZERO_BYTE      8'h00

// ==========================================================
// Command codes, command address pattern and reserved fill
// ==========================================================
`define FLQ_CMD_QUERY_A    8'h90
`define FLQ_CMD_QUERY_B    8'h98
`define FLQ_CMD_RESET      8'hF0
`define FLQ_THIRD_COMMAND_ADDRESS_PATTERN 8'h55
`define FLQ_RESERVED_FILL  8'hFF

// ==========================================================
// Table word offsets (within the selected sector)
// ==========================================================
`define FLQ_OFS_MIN_PROG_SUPPLY     8'h1B
`define FLQ_OFS_MAX_PROG_SUPPLY     8'h1C
`define FLQ_OFS_MIN_AUX_SUPPLY      8'h1D
`define FLQ_OFS_MAX_AUX_SUPPLY      8'h1E
`define FLQ_OFS_TYP_WORD_PROG       8'h1F
`define FLQ_OFS_TYP_BUF_PROG        8'h20
`define FLQ_OFS_TYP_BLOCK_ERASE     8'h21
`define FLQ_OFS_TYP_DEV_ERASE       8'h22
`define FLQ_OFS_MAX_WORD_PROG       8'h23
`define FLQ_OFS_MAX_BUF_PROG        8'h24
`define FLQ_OFS_MAX_BLOCK_ERASE     8'h25
`define FLQ_OFS_MAX_DEV_ERASE       8'h26
`define FLQ_OFS_CAPACITY_EXP        8'h27
`define FLQ_OFS_IF_WIDTH_LO         8'h28
`define FLQ_OFS_IF_WIDTH_HI         8'h29
`define FLQ_OFS_WBUF_SIZE_LO        8'h2A
`define FLQ_OFS_WBUF_SIZE_HI        8'h2B
`define FLQ_OFS_REGION_COUNT        8'h2C
`define FLQ_OFS_REGION_BLOCKS_LO    8'h2D
`define FLQ_OFS_REGION_BLOCKS_HI    8'h2E
`define FLQ_OFS_REGION_BSIZE_LO     8'h2F
`define FLQ_OFS_REGION_BSIZE_HI     8'h30
`define FLQ_OFS_EXT_SIG_0           8'h40
`define FLQ_OFS_EXT_SIG_1           8'h41
`define FLQ_OFS_EXT_SIG_2           8'h42
`define FLQ_OFS_EXT_MAJOR           8'h43
`define FLQ_OFS_EXT_MINOR           8'h44
`define FLQ_OFS_UNLOCK_PROCESS      8'h45
`define FLQ_OFS_ERASE_SUSPEND       8'h46
`define FLQ_OFS_PROTECT_GROUP       8'h47
`define FLQ_OFS_TEMP_UNPROTECT      8'h48
`define FLQ_OFS_PROTECT_SCHEME      8'h49

// ==========================================================
// Table word values (low byte; high byte is always zero)
// ==========================================================
`define FLQ_VAL_MIN_PROG_SUPPLY     8'h17
`define FLQ_VAL_MAX_PROG_SUPPLY     8'h19
`define FLQ_VAL_MIN_AUX_SUPPLY      8'h85
`define FLQ_VAL_MAX_AUX_SUPPLY      8'h95
`define FLQ_VAL_TYP_WORD_PROG       8'h05
`define FLQ_VAL_TYP_BUF_PROG        8'h08
`define FLQ_VAL_TYP_BLOCK_ERASE     8'h08
`define FLQ_VAL_TYP_DEV_ERASE       8'h10
`define FLQ_VAL_MAX_WORD_PROG       8'h02
`define FLQ_VAL_MAX_BUF_PROG        8'h02
`define FLQ_VAL_MAX_BLOCK_ERASE     8'h01
`define FLQ_VAL_MAX_DEV_ERASE       8'h01
`define FLQ_VAL_CAPACITY_EXP        8'h1B
`define FLQ_VAL_IF_WIDTH_LO         8'h01
`define FLQ_VAL_IF_WIDTH_HI         8'h00
`define FLQ_VAL_WBUF_SIZE_LO        8'h09
`define FLQ_VAL_WBUF_SIZE_HI        8'h00
`define FLQ_VAL_REGION_COUNT        8'h01
`define FLQ_VAL_REGION_BLOCKS_LO    8'hFF
`define FLQ_VAL_REGION_BLOCKS_HI    8'h03
`define FLQ_VAL_REGION_BSIZE_LO     8'h00
`define FLQ_VAL_REGION_BSIZE_HI     8'h02
`define FLQ_VAL_EXT_SIG_0           8'h50
`define FLQ_VAL_EXT_SIG_1           8'h52
`define FLQ_VAL_EXT_SIG_2           8'h49
`define FLQ_VAL_EXT_MAJOR           8'h31
`define FLQ_VAL_EXT_MINOR           8'h35
`define FLQ_VAL_UNLOCK_PROCESS      8'h21
`define FLQ_VAL_ERASE_SUSPEND       8'h02
`define FLQ_VAL_PROTECT_GROUP       8'h01
`define FLQ_VAL_TEMP_UNPROTECT      8'h00
`define FLQ_VAL_PROTECT_SCHEME      8'h09

`endif

// file: logic/flq_table_rom.v
`timescale 1ns/1ps
`include "flq_map.vh"

// ==========================================================
// Query parameter table lookup (pure combinational)
// ==========================================================
module flq_table_rom #(
  parameter [7:0] FILL = `FLQ_RESERVED_FILL  // Value of offsets outside the table
) (
  input  wire [7:0] i_offset,                // Word offset within the sector
  output reg  [7:0] o_byte                   // Low byte of the table word
);

  // Constant table; no state, so order of reads never matters
  always @* begin
    case (i_offset)
      `FLQ_OFS_MIN_PROG_SUPPLY:  o_byte = `FLQ_VAL_MIN_PROG_SUPPLY;
      `FLQ_OFS_MAX_PROG_SUPPLY:  o_byte = `FLQ_VAL_MAX_PROG_SUPPLY;
      `FLQ_OFS_MIN_AUX_SUPPLY:   o_byte = `FLQ_VAL_MIN_AUX_SUPPLY;
      `FLQ_OFS_MAX_AUX_SUPPLY:   o_byte = `FLQ_VAL_MAX_AUX_SUPPLY;
      `FLQ_OFS_TYP_WORD_PROG:    o_byte = `FLQ_VAL_TYP_WORD_PROG;
      `FLQ_OFS_TYP_BUF_PROG:     o_byte = `FLQ_VAL_TYP_BUF_PROG;
      `FLQ_OFS_TYP_BLOCK_ERASE:  o_byte = `FLQ_VAL_TYP_BLOCK_ERASE;
      `FLQ_OFS_TYP_DEV_ERASE:    o_byte = `FLQ_VAL_TYP_DEV_ERASE;
      `FLQ_OFS_MAX_WORD_PROG:    o_byte = `FLQ_VAL_MAX_WORD_PROG;
      `FLQ_OFS_MAX_BUF_PROG:     o_byte = `FLQ_VAL_MAX_BUF_PROG;
      `FLQ_OFS_MAX_BLOCK_ERASE:  o_byte = `FLQ_VAL_MAX_BLOCK_ERASE;
      `FLQ_OFS_MAX_DEV_ERASE:    o_byte = `FLQ_VAL_MAX_DEV_ERASE;
      `FLQ_OFS_CAPACITY_EXP:     o_byte = `FLQ_VAL_CAPACITY_EXP;
      `FLQ_OFS_IF_WIDTH_LO:      o_byte = `FLQ_VAL_IF_WIDTH_LO;
      `FLQ_OFS_IF_WIDTH_HI:      o_byte = `FLQ_VAL_IF_WIDTH_HI;
      `FLQ_OFS_WBUF_SIZE_LO:     o_byte = `FLQ_VAL_WBUF_SIZE_LO;
      `FLQ_OFS_WBUF_SIZE_HI:     o_byte = `FLQ_VAL_WBUF_SIZE_HI;
      `FLQ_OFS_REGION_COUNT:     o_byte = `FLQ_VAL_REGION_COUNT;
      `FLQ_OFS_REGION_BLOCKS_LO: o_byte = `FLQ_VAL_REGION_BLOCKS_LO;
      `FLQ_OFS_REGION_BLOCKS_HI: o_byte = `FLQ_VAL_REGION_BLOCKS_HI;
      `FLQ_OFS_REGION_BSIZE_LO:  o_byte = `FLQ_VAL_REGION_BSIZE_LO;
      `FLQ_OFS_REGION_BSIZE_HI:  o_byte = `FLQ_VAL_REGION_BSIZE_HI;
      `FLQ_OFS_EXT_SIG_0:        o_byte = `FLQ_VAL_EXT_SIG_0;
      `FLQ_OFS_EXT_SIG_1:        o_byte = `FLQ_VAL_EXT_SIG_1;
      `FLQ_OFS_EXT_SIG_2:        o_byte = `FLQ_VAL_EXT_SIG_2;
      `FLQ_OFS_EXT_MAJOR:        o_byte = `FLQ_VAL_EXT_MAJOR;
      `FLQ_OFS_EXT_MINOR:        o_byte = `FLQ_VAL_EXT_MINOR;
      `FLQ_OFS_UNLOCK_PROCESS:   o_byte = `FLQ_VAL_UNLOCK_PROCESS;
      `FLQ_OFS_ERASE_SUSPEND:    o_byte = `FLQ_VAL_ERASE_SUSPEND;
      `FLQ_OFS_PROTECT_GROUP:    o_byte = `FLQ_VAL_PROTECT_GROUP;
      `FLQ_OFS_TEMP_UNPROTECT:   o_byte = `FLQ_VAL_TEMP_UNPROTECT;
      `FLQ_OFS_PROTECT_SCHEME:   o_byte = `FLQ_VAL_PROTECT_SCHEME;
      // Reserved or uncovered offsets read a stable fill
      default:                   o_byte = FILL;
    endcase
  end

endmodule

// file: logic/flq_query_table.v
// What this block does
// - Query command at third pattern enters query when all banks idle
// - Only reset command leaves query mode
// - Upper data byte of table words zero
// - Main supply limits read 0017h, 0019h
// - Auxiliary supply limits read 0085h, 0095h
// - Offset 1Fh reads 0005h
// - Offset 20h reads 0008h
// - Offset 21h reads 0008h
// - Offset 22h reads 0010h
// - Offset 23h reads 0002h
// - Offset 24h reads 0002h
// - Offset 25h reads 0001h
// - Offset 26h reads 0001h
// - Offset 27h reads capacity exponent 001Bh
// - Offsets 28h, 29h read 0001h, 0000h
// - Offsets 2Ah, 2Bh read 0009h, 0000h
// - Offset 2Ch reads one erase region
// - Block count words 00FFh, 0003h
// - Block size words 0000h, 0002h
// - Offsets 40h-42h read signature codes
// - Offsets 43h, 44h read 0031h, 0035h
// - Offset 45h reads 0021h
// - Offset 46h reads 0002h
// - Offset 47h reads 0001h
// - Offset 48h reads 0000h
// - Offset 49h reads 0009h
`timescale 1ns/1ps
`include "flq_map.vh"

// ==========================================================
// Flash query parameter table with query-mode control
// ==========================================================
module flq_query_table #(
  parameter       ADDR_W    = 23,                  // Word address width
  parameter [7:0] RESET_CMD = `FLQ_CMD_RESET,      // Command that leaves query mode
  parameter [7:0] FILL      = `FLQ_RESERVED_FILL   // Reserved offset fill value
) (
  input  wire                   i_clock,           // Bus clock
  input  wire                   i_srst,            // Synchronous reset, high
  input  wire [ADDR_W-1:0]      i_addr,            // Word address of the access
  input  wire [`FLQ_DATA_W-1:0] i_wdata,           // Command write data
  input  wire                   i_we,              // Write strobe, one cycle
  input  wire                   i_re,              // Read strobe, one cycle
  input  wire                   i_banks_idle,      // All banks in read mode
  input  wire [`FLQ_DATA_W-1:0] i_array_rdata,     // Array data for normal reads
  output wire [`FLQ_DATA_W-1:0] o_rdata,           // Read data
  output wire                   o_rvalid,          // Read data valid pulse
  output wire                   o_query_mode,      // Query mode active
  output wire                   o_cmd_reject       // Query entry refused pulse
);

  // ========================================================
  // State encoding (one-hot)
  // ========================================================
  localparam [1:0] ST_ARRAY = 2'b01;               // Normal array reads
  localparam [1:0] ST_QUERY = 2'b10;               // Table reads

  // ========================================================
  // Helper functions
  // ========================================================

  // True when the command byte asks for query mode
  function is_query_cmd;
    input [`FLQ_BYTE_W-1:0] cmd;
    begin
      is_query_cmd = (cmd == `FLQ_CMD_QUERY_A) || (cmd == `FLQ_CMD_QUERY_B);
    end
  endfunction

  // True when the low word bits match the third pattern
  function is_third_command_address_pattern;
    input [ADDR_W-1:0] addr;
    begin
      is_third_command_address_pattern =
        (addr[`FLQ_BYTE_W-1:0] == `FLQ_THIRD_COMMAND_ADDRESS_PATTERN);
    end
  endfunction

  // Offset within the sector; upper address bits are ignored
  function [`FLQ_SEC_OFS_W-1:0] sector_offset;
    input [ADDR_W-1:0] addr;
    begin
      sector_offset = addr[`FLQ_SEC_OFS_W-1:0];
    end
  endfunction

  // ========================================================
  // Registers
  // ========================================================
  reg  [1:0]              state_r;                 // Current mode
  reg  [1:0]              state_nxt;               // Next mode
  reg  [`FLQ_DATA_W-1:0]  rdata_r;                 // Read data register
  reg  [`FLQ_DATA_W-1:0]  rdata_nxt;               // Next read data
  reg                     rvalid_r;                // Read valid register
  reg                     query_r;                 // Query mode flag output
  reg                     reject_r;                // Refused entry pulse
  reg                     reject_nxt;              // Next refused pulse

  // ========================================================
  // Combinational signals
  // ========================================================
  wire [`FLQ_BYTE_W-1:0]    cmd_byte;              // Low data byte of a write
  wire [`FLQ_SEC_OFS_W-1:0] rd_offset;             // Sector offset of a read
  wire                      in_table_page;         // Offset below 100h
  wire [`FLQ_BYTE_W-1:0]    rom_byte;              // Table lookup result
  wire [`FLQ_BYTE_W-1:0]    table_byte;            // Table byte or fill
  wire                      query_req;             // Query command written
  wire                      reset_req;             // Reset command written

  // Upper command data bits are don't care
  assign cmd_byte = i_wdata[`FLQ_BYTE_W-1:0];

  // Offset used for table lookup
  assign rd_offset = sector_offset(i_addr);

  // Only the first page of the sector holds the table
  assign in_table_page =
    (rd_offset[`FLQ_SEC_OFS_W-1:`FLQ_BYTE_W] == {(`FLQ_SEC_OFS_W-`FLQ_BYTE_W){1'b0}});

  assign query_req = i_we && is_query_cmd(cmd_byte) && is_third_command_address_pattern(i_addr);

  assign reset_req = i_we && (cmd_byte == RESET_CMD);

  // ========================================================
  // Table lookup
  // ========================================================

  flq_table_rom #(
    .FILL     (FILL)
  ) u_rom (
    .i_offset (rd_offset[`FLQ_BYTE_W-1:0]),
    .o_byte   (rom_byte)
  );

  assign table_byte = in_table_page ? rom_byte : FILL;

  // ========================================================
  // Mode state machine
  // ========================================================

  // Next mode and refused-entry pulse
  always @* begin
    state_nxt  = state_r;
    reject_nxt = 1'b0;
    case (state_r)
      // Array mode: wait for a query command
      ST_ARRAY: begin
        if (query_req && i_banks_idle) begin
          state_nxt = ST_QUERY;
        end else if (query_req) begin
          reject_nxt = 1'b1;
        end
      end
      // Query mode: stay until reset command
      ST_QUERY: begin
        if (reset_req) begin
          state_nxt = ST_ARRAY;
        end
      end
      // Illegal code recovers to array mode
      default: begin
        state_nxt = ST_ARRAY;
      end
    endcase
  end

  // Mode and status registers
  always @(posedge i_clock) begin
    if (i_srst) begin
      state_r  <= ST_ARRAY;
      query_r  <= 1'b0;
      reject_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      query_r  <= (state_nxt == ST_QUERY);
      reject_r <= reject_nxt;
    end
  end

  // ========================================================
  // Read path
  // ========================================================

  // Select data by the mode in force when the read is taken
  always @* begin
    rdata_nxt = rdata_r;
    if (i_re) begin
      if (state_r == ST_QUERY) begin
        rdata_nxt = {`FLQ_ZERO_BYTE, table_byte};
      end else begin
        // Array mode passes memory data through
        rdata_nxt = i_array_rdata;
      end
    end
  end

  // Read data and valid registers
  always @(posedge i_clock) begin
    if (i_srst) begin
      rdata_r  <= {`FLQ_DATA_W{1'b0}};
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= i_re;
    end
  end

  // ========================================================
  // Outputs, all from flip-flops
  // ========================================================
  assign o_rdata      = rdata_r;
  assign o_rvalid     = rvalid_r;
  assign o_query_mode = query_r;
  assign o_cmd_reject = reject_r;

endmodule

// file: verif/flq_query_table_asserts.sv
`timescale 1ns/1ps

// ==========================================================
// Port-level checks of the query table
// ==========================================================
module flq_query_table_asserts #(
  parameter ADDR_W = 23                  // Word address width
) (
  input logic              i_clock,      // Bus clock
  input logic              i_srst,       // Synchronous reset
  input logic [ADDR_W-1:0] i_addr,       // Access address
  input logic [15:0]       i_wdata,      // Command data
  input logic              i_we,         // Write strobe
  input logic              i_re,         // Read strobe
  input logic              i_banks_idle, // Banks idle
  input logic [15:0]       i_array_rdata,// Array data
  input logic [15:0]       o_rdata,      // Read data
  input logic              o_rvalid,     // Read valid
  input logic              o_query_mode, // Query mode
  input logic              o_cmd_reject  // Refused entry
);
  // Query command at the third pattern
  wire qcmd = i_we && i_addr[7:0] == 8'h55 && (i_wdata[7:0] == 8'h90 || i_wdata[7:0] == 8'h98);
  // Table read taken in query mode
  wire qrd  = i_re && o_query_mode;
  // Reset command write
  wire rcmd = i_we && i_wdata[7:0] == 8'hF0;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  chk_enter_query: assert property (
    qcmd && i_banks_idle && !o_query_mode |=> o_query_mode) else $error("query entry missed");
  chk_refuse_busy: assert property (
    qcmd && !i_banks_idle && !o_query_mode |=> o_cmd_reject && !o_query_mode)
    else $error("busy entry not refused");
  chk_reject_cause: assert property (
    !(qcmd && !i_banks_idle && !o_query_mode) |=> !o_cmd_reject) else $error("stray reject");
  chk_exit_reset: assert property (
    o_query_mode && rcmd |=> !o_query_mode) else $error("reset did not leave query");
  chk_mode_stays: assert property (
    o_query_mode && !rcmd |=> o_query_mode) else $error("query mode dropped");
  chk_array_path: assert property (
    i_re && !o_query_mode |=> o_rvalid && o_rdata == $past(i_array_rdata))
    else $error("array read wrong");
  chk_high_zero: assert property (
    qrd |=> o_rvalid && o_rdata[15:8] == 8'h00) else $error("high byte not zero");
  chk_supply_min: assert property (
    qrd && i_addr[11:0] == 12'h01B |=> o_rdata == 16'h0017) else $error("supply min wrong");
  chk_word_time: assert property (
    qrd && i_addr[11:0] == 12'h01F |=> o_rdata == 16'h0005) else $error("word time wrong");
  chk_capacity_exp: assert property (
    qrd && i_addr[11:0] == 12'h027 |=> o_rdata == 16'h001B) else $error("capacity wrong");
  chk_block_count: assert property (
    qrd && i_addr[11:0] == 12'h02D |=> o_rdata == 16'h00FF) else $error("block count wrong");
  chk_ext_signature: assert property (
    qrd && i_addr[11:0] == 12'h040 |=> o_rdata == 16'h0050) else $error("signature wrong");
  chk_lock_scheme: assert property (
    qrd && i_addr[11:0] == 12'h049 |=> o_rdata == 16'h0009) else $error("scheme wrong");
endmodule

bind flq_query_table flq_query_table_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_we(i_we), .i_re(i_re), .i_banks_idle(i_banks_idle), .i_array_rdata(i_array_rdata),
  .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_query_mode(o_query_mode),
  .o_cmd_reject(o_cmd_reject));

// file: verif/flq_host_model.sv
`timescale 1ns/1ps

// ==========================================================
// Host memory controller issuing commands and reads
// ==========================================================
module flq_host_model (
  input  logic        i_clock,  // Bus clock
  input  logic [15:0] i_rdata,  // Read data from the table
  input  logic        i_rvalid, // Read data valid
  output logic [22:0] o_addr,   // Word address
  output logic [15:0] o_wdata,  // Command data
  output logic        o_we,     // Write strobe
  output logic        o_re      // Read strobe
);
  // Idle bus at time zero
  initial begin
    o_addr = 23'h2AAAAA;
    o_wdata = 16'h5A5A;
    o_we = 1'b0;
    o_re = 1'b0;
  end

  task automatic wr(input logic [22:0] a, input logic [15:0] w);
    @(posedge i_clock);
    o_addr <= a;
    o_wdata <= w;
    o_we <= 1'b1;
    @(posedge i_clock);
    o_we <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~w;
    #1;
  endtask

  // One read, data taken when valid stands
  task automatic rd(input logic [22:0] a, output logic [15:0] d, output logic v);
    @(posedge i_clock);
    o_addr <= a;
    o_re <= 1'b1;
    @(posedge i_clock);
    o_re <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule

// file: verif/flq_query_table_bench.sv
`timescale 1ns/1ps

// ==========================================================
// Self-checking bench of the query table
// ==========================================================
module flq_query_table_bench;
  logic        i_clock;       // Bus clock
  logic        i_srst;        // Reset
  logic        i_banks_idle;  // Banks idle level
  logic [15:0] i_array_rdata; // Array read data
  wire  [22:0] i_addr;        // Host address
  wire  [15:0] i_wdata;       // Host write data
  wire         i_we;          // Host write strobe
  wire         i_re;          // Host read strobe
  wire  [15:0] o_rdata;       // Read data
  wire         o_rvalid;      // Read valid
  wire         o_query_mode;  // Query mode flag
  wire         o_cmd_reject;  // Refused entry pulse
  int          n_errors;      // Mismatch count
  int          cmp_count;     // Comparison count
  logic [15:0] d;             // Last read word
  logic        v;             // Last read valid
  logic [22:0] base;          // Sector base
  // Expected low bytes, offsets 1Bh to 30h and 40h to 49h
  logic [7:0]  tab_a [0:21] = '{8'h17, 8'h19, 8'h85, 8'h95, 8'h05, 8'h08, 8'h08, 8'h10,
    8'h02, 8'h02, 8'h01, 8'h01, 8'h1B, 8'h01, 8'h00, 8'h09, 8'h00, 8'h01, 8'hFF, 8'h03,
    8'h00, 8'h02};
  logic [7:0]  tab_b [0:9] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h35, 8'h21, 8'h02, 8'h01,
    8'h00, 8'h09};

  flq_query_table uut (.i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .i_banks_idle(i_banks_idle),
    .i_array_rdata(i_array_rdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_query_mode(o_query_mode), .o_cmd_reject(o_cmd_reject));
  flq_host_model host (.i_clock(i_clock), .i_rdata(o_rdata), .i_rvalid(o_rvalid),
    .o_addr(i_addr), .o_wdata(i_wdata), .o_we(i_we), .o_re(i_re));

  // Clock of 100 ns
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  // Word and flag compares
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic rd_chk(input logic [22:0] a, input logic [15:0] e);
    host.rd(a, d, v);
    chk_bit(v, 1'b1);
    chk_word(d, e);
  endtask

  // Verdict and end of run
  task automatic report_and_stop;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #500000;
    n_errors++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    n_errors = 0;
    cmp_count = 0;
    i_srst = 1'b1;
    i_banks_idle = 1'b1;
    i_array_rdata = 16'hA5C3;
    repeat (5) @(posedge i_clock);
    i_srst <= 1'b0;
    @(posedge i_clock);
    #1;
    // Reset leaves every output at its idle value
    chk_bit(o_query_mode, 1'b0);
    chk_word(o_rdata, 16'h0000);
    chk_bit(o_rvalid, 1'b0);
    chk_bit(o_cmd_reject, 1'b0);
    rd_chk(23'h000020, 16'hA5C3);
    @(posedge i_clock) i_banks_idle <= 1'b0;
    host.wr(23'h000055, 16'h0098);
    chk_bit(o_cmd_reject, 1'b1);
    chk_bit(o_query_mode, 1'b0);
    @(posedge i_clock) i_banks_idle <= 1'b1;
    host.wr(23'h0000AA, 16'h0098);
    chk_bit(o_query_mode, 1'b0);
    host.wr(23'h000055, 16'h0090);
    chk_bit(o_query_mode, 1'b1);
    // A second query command neither leaves nor refuses
    host.wr(23'h000055, 16'h0098);
    chk_bit(o_query_mode, 1'b1);
    chk_bit(o_cmd_reject, 1'b0);
    host.wr(23'h000000, 16'h0000);
    chk_bit(o_query_mode, 1'b1);
    host.wr(23'h000000, 16'h00F0);
    chk_bit(o_query_mode, 1'b0);
    @(posedge i_clock) i_array_rdata <= 16'h3C5A;
    rd_chk(23'h00001B, 16'h3C5A);
    host.wr(23'h7FFF55, 16'h0098);
    chk_bit(o_query_mode, 1'b1);
    // Whole table from two sector bases
    for (int s = 0; s < 2; s++) begin
      base = (s == 0) ? 23'h012000 : 23'h7FF000;
      for (int k = 0; k < 22; k++) begin
        if (k < 4)       rd_chk(base + 23'(k + 27), {8'h00, tab_a[k]});
        else if (k < 9)  rd_chk(base + 23'(k + 27), {8'h00, tab_a[k]});
        else if (k < 13) rd_chk(base + 23'(k + 27), {8'h00, tab_a[k]});
        else             rd_chk(base + 23'(k + 27), {8'h00, tab_a[k]});
      end
      for (int k = 0; k < 10; k++) begin
        rd_chk(base + 23'(k + 64), {8'h00, tab_b[k]});
      end
      // Outside the first page the fill is seen; reserved offset 31h reads a zero high byte
      rd_chk(base + 23'h00011B, 16'h00FF);
      host.rd(base + 23'h000031, d, v);
      chk_word(d & 16'hFF00, 16'h0000);
    end
    host.wr(23'h000000, 16'h00F0);
    chk_bit(o_query_mode, 1'b0);
    report_and_stop;
  end
endmodule
